// ---- core/mcc_cmd.sv ----
// Calibration command interpreter on the byte stream of the SPI port
`include "mcc_params.svh"
`default_nettype none

// Overview of operation
// - Command 0x02 returns three low-gain current constants, phases A,B,C.
// - Command 0x82 stores three low-gain current constants unaided.
// - Low-gain current constant defaults to 0x7000 for every phase.
// - Command 0x03 returns three high-gain current constants, phases A,B,C.
// - Command 0x83 stores three high-gain current constants persistently.
// - High-gain current constant defaults to 0x2300 for every phase.
// - A read after a write returns the newly stored values.
// - Gain switches automatically; separate power constants per gain.
// - Commands 0x07, 0x09, 0x0B return low-gain power of A, B, C.
// - Low-gain power constant defaults to 0x3EE4 for every phase.
// - Commands 0x87, 0x89, 0xB9 store low-gain power of A, B, C.
// - Commands 0x06, 0x08, 0x0A return high-gain power of A, B, C.
// - High-gain power constant defaults to 0xAA0 for every phase.
// - Commands 0x86, 0x88, 0x8A store high-gain power of A, B, C.
// - Command 0x15 returns guard then start for A, B, then C.
// - Start defaults to 0x08, guard to 0x20, for every phase.
// - Command 0x95 plus six guard/start bytes stores new compensation.
// - Write packets are ten bytes: 0xEE, command, data, pads, checksum.
// - Every accepted command is acknowledged with command plus 0x30.
module mcc_cmd #(
  parameter int NW = `MCC_NWORDS
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_byte,
  input  wire logic             tx_ready,
  output logic                  tx_valid,
  output logic      [7:0]       tx_byte,
  input  wire logic             gain_low,
  output mcc_pkg::mcc_act_t     act,
  output logic                  busy
);

  mcc_pkg::mcc_state_t state_r;
  mcc_pkg::mcc_dec_t   dec_r;
  logic [7:0]          cmd_r;
  logic [3:0]          cnt_r;
  logic [2:0]          ridx_r;
  logic [7:0]          buf_r [6];
  logic [2:0]          we_r;
  logic                tx_valid_r;
  logic [7:0]          tx_byte_r;
  mcc_pkg::mcc_act_t   act_r;
  logic                busy_r;
  logic [NW-1:0][15:0] words;
  logic [2:0][15:0]    wdata;
  logic                rx_take;
  logic                tx_done;
  mcc_pkg::mcc_dec_t   dec_in;

  // Command decode: direction, first word, number of words
  function automatic mcc_pkg::mcc_dec_t decode(input logic [7:0] c);
    mcc_pkg::mcc_dec_t d;
    d = '{valid: 1'b1, wr: c[7], base: `MCC_IX_CUR_LO, nw: 2'd1};
    case (c)
      `MCC_RD_CUR_LO, `MCC_WR_CUR_LO: d.nw = 2'd3;
      `MCC_RD_CUR_HI, `MCC_WR_CUR_HI: begin
        d.base = `MCC_IX_CUR_HI;
        d.nw   = 2'd3;
      end
      `MCC_RD_PLO_A, `MCC_WR_PLO_A: d.base = `MCC_IX_PLO;
      `MCC_RD_PLO_B, `MCC_WR_PLO_B: d.base = `MCC_IX_PLO + 4'h1;
      `MCC_RD_PLO_C, `MCC_WR_PLO_C: d.base = `MCC_IX_PLO + 4'h2;
      `MCC_RD_PHI_A, `MCC_WR_PHI_A: d.base = `MCC_IX_PHI;
      `MCC_RD_PHI_B, `MCC_WR_PHI_B: d.base = `MCC_IX_PHI + 4'h1;
      `MCC_RD_PHI_C, `MCC_WR_PHI_C: d.base = `MCC_IX_PHI + 4'h2;
      `MCC_RD_COMP, `MCC_WR_COMP: begin
        d.base = `MCC_IX_COMP;
        d.nw   = 2'd3;
      end
      default: d.valid = 1'b0;
    endcase
    return d;
  endfunction : decode

  // Response byte i: word i/2 of the command, high byte first
  function automatic logic [7:0] rsp_byte(
    input logic [NW-1:0][15:0] w,
    input mcc_pkg::mcc_dec_t   d,
    input logic [2:0]          i
  );
    logic [15:0] v;
    logic [1:0]  k;
    k = i[2:1];
    v = 16'h0000;
    if (k < d.nw) begin
      v = w[int'(d.base) + int'(k)];
    end
    return i[0] ? v[7:0] : v[15:8];
  endfunction : rsp_byte

  assign rx_take = rx_valid && (state_r != mcc_pkg::MCC_ACK)
                && (state_r != mcc_pkg::MCC_SEND);
  assign tx_done = tx_valid_r && tx_ready;
  assign dec_in  = decode(rx_byte);

  // Buffered data bytes form words high byte first
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      wdata[k] = {buf_r[2*k], buf_r[2*k+1]};
    end
  end

  mcc_store #(
    .NW (NW)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .we      (we_r),
    .base    (dec_r.base),
    .wdata   (wdata),
    .words   (words)
  );

  // Packet sequencing; bytes during the answer are dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= mcc_pkg::MCC_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      case (state_r)
        mcc_pkg::MCC_IDLE: begin
          if (rx_take && rx_byte == `MCC_SOP) begin
            state_r <= mcc_pkg::MCC_CMD;
            cnt_r   <= 4'h1;
          end
        end
        mcc_pkg::MCC_CMD: begin
          if (rx_take) begin
            cnt_r <= `MCC_CMD_POS;
            if (!dec_in.valid) begin
              state_r <= mcc_pkg::MCC_IDLE;             // Unknown: no ack
            end else if (dec_in.wr) begin
              state_r <= mcc_pkg::MCC_DATA;
            end else begin
              state_r <= mcc_pkg::MCC_ACK;
            end
          end
        end
        mcc_pkg::MCC_DATA: begin
          if (rx_take) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r + 4'h1 == `MCC_PKT_LEN) begin
              state_r <= mcc_pkg::MCC_ACK;
            end
          end
        end
        mcc_pkg::MCC_ACK: begin
          if (tx_done) begin
            state_r <= dec_r.wr ? mcc_pkg::MCC_IDLE : mcc_pkg::MCC_SEND;
          end
        end
        mcc_pkg::MCC_SEND: begin
          if (tx_done && ridx_r == `MCC_RSP_LAST) begin
            state_r <= mcc_pkg::MCC_IDLE;
          end
        end
        default: state_r <= mcc_pkg::MCC_IDLE;
      endcase
    end
  end

  // Latch the command and its decode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_r <= 8'h00;
      dec_r <= '0;
    end else if (state_r == mcc_pkg::MCC_CMD && rx_take) begin
      cmd_r <= rx_byte;
      dec_r <= dec_in;
    end
  end

  // Capture data bytes 3..8; pad and checksum are not checked
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (state_r == mcc_pkg::MCC_DATA && rx_take
                 && cnt_r + 4'h1 >= `MCC_DAT_FIRST
                 && cnt_r + 4'h1 <= `MCC_DAT_LAST) begin
      buf_r[3'(cnt_r + 4'h1 - `MCC_DAT_FIRST)] <= rx_byte;
    end
  end

  // Enables set on the last packet byte; the store writes on the same edge that raises the acknowledge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      we_r <= 3'b000;
    end else if (state_r == mcc_pkg::MCC_DATA && rx_take
                 && cnt_r + 4'h1 == `MCC_PKT_LEN) begin
      for (int k = 0; k < 3; k++) begin
        we_r[k] <= (2'(k) < dec_r.nw);
      end
    end else begin
      we_r <= 3'b000;
    end
  end

  // Transmit side: acknowledge, then six bytes for a read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_byte_r  <= 8'h00;
      ridx_r     <= 3'h0;
    end else if (state_r == mcc_pkg::MCC_ACK && !tx_valid_r) begin
      tx_valid_r <= 1'b1;
      tx_byte_r  <= cmd_r + `MCC_ACK_OFS;
      ridx_r     <= 3'h0;
    end else if (tx_done && state_r == mcc_pkg::MCC_ACK && !dec_r.wr) begin
      tx_byte_r  <= rsp_byte(words, dec_r, 3'h0);
    end else if (tx_done && state_r == mcc_pkg::MCC_SEND
                 && ridx_r != `MCC_RSP_LAST) begin
      ridx_r     <= ridx_r + 3'h1;
      tx_byte_r  <= rsp_byte(words, dec_r, ridx_r + 3'h1);
    end else if (tx_done) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Gain-dependent constants; low gain means high current
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_r <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        act_r.cur[p]  <= gain_low ? words[int'(`MCC_IX_CUR_LO) + p]
                                  : words[int'(`MCC_IX_CUR_HI) + p];
        act_r.pwr[p]  <= gain_low ? words[int'(`MCC_IX_PLO) + p]
                                  : words[int'(`MCC_IX_PHI) + p];
        act_r.comp[p] <= gain_low ? words[int'(`MCC_IX_COMP) + p][7:0]
                                  : words[int'(`MCC_IX_COMP) + p][15:8];
      end
    end
  end

  // Busy while a packet is open
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r != mcc_pkg::MCC_IDLE);
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_byte  = tx_byte_r;
  assign act      = act_r;
  assign busy     = busy_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_write_end;
    state_r == mcc_pkg::MCC_DATA && rx_take && cnt_r == `MCC_PKT_LEN - 4'h1;
  endsequence

  sequence s_ack_out;
    state_r == mcc_pkg::MCC_ACK && tx_valid_r;
  endsequence

  AST_DEF_CUR_LO: assert property ($past(rst) |->
    words[0] == `MCC_DEF_CUR_LO && words[2] == `MCC_DEF_CUR_LO)
    else $error("low-gain current default wrong");
  AST_DEF_CUR_HI: assert property ($past(rst) |->
    words[3] == `MCC_DEF_CUR_HI && words[5] == `MCC_DEF_CUR_HI)
    else $error("high-gain current default wrong");
  AST_DEF_PWR: assert property ($past(rst) |->
    words[6] == `MCC_DEF_PLO && words[11] == `MCC_DEF_PHI)
    else $error("power default wrong");
  AST_DEF_COMP: assert property ($past(rst) |->
    words[12] == {`MCC_DEF_GUARD, `MCC_DEF_START})
    else $error("compensation default wrong");
  AST_ACK_VALUE: assert property (s_ack_out |->
    tx_byte_r == cmd_r + `MCC_ACK_OFS)
    else $error("acknowledge byte wrong");
  AST_WR_LEN: assert property ((|we_r) |->
    $past(state_r == mcc_pkg::MCC_DATA && cnt_r == `MCC_PKT_LEN - 4'h1))
    else $error("store written before tenth byte");
  AST_WR_STORE: assert property (s_write_end ##1 (|we_r) |=>
    words[dec_r.base] == wdata[0])
    else $error("written word not stored");
  AST_ACK_AFTER_WR: assert property (s_write_end |=> ##[1:2]
    s_ack_out)
    else $error("no acknowledge after write");
  AST_RD_FIRST: assert property (
    state_r == mcc_pkg::MCC_ACK && tx_done && !dec_r.wr |=>
    tx_valid_r && tx_byte_r == words[dec_r.base][15:8])
    else $error("first read byte not high byte");
  AST_GAIN_SEL: assert property (gain_low |=>
    act_r.pwr[0] == $past(words[6]))
    else $error("low-gain power not selected");
  AST_TX_HOLD: assert property (tx_valid_r && !tx_ready |=>
    tx_valid_r && $stable(tx_byte_r))
    else $error("response byte dropped under stall");

  // Steps of the answer phase, shared by the checks below
  sequence s_rd_cmd;
    state_r == mcc_pkg::MCC_CMD && rx_take && dec_in.valid && !dec_in.wr;
  endsequence

  sequence s_rd_last;
    state_r == mcc_pkg::MCC_SEND && tx_done && ridx_r == `MCC_RSP_LAST;
  endsequence

  sequence s_bad_cmd;
    state_r == mcc_pkg::MCC_CMD && rx_take && !dec_in.valid;
  endsequence

  sequence s_wr_ack_taken;
    state_r == mcc_pkg::MCC_ACK && tx_done && dec_r.wr;
  endsequence

  // Single-phase power reads: bytes after the word are padding
  sequence s_pwr_pad;
    state_r == mcc_pkg::MCC_SEND && tx_done && dec_r.nw == 2'd1
      && ridx_r != 3'h0 && ridx_r != `MCC_RSP_LAST;
  endsequence

  // Take of the phase A low byte on a three-word read
  sequence s_word1_next;
    state_r == mcc_pkg::MCC_SEND && tx_done && ridx_r == 3'h1
      && dec_r.nw == 2'd3;
  endsequence

  // Answer shape: acknowledge delay, length, padding and phase order
  AST_ACK_AFTER_RD: assert property (s_rd_cmd |=> ##1 s_ack_out)
    else $error("no acknowledge after read command");
  AST_RD_LENGTH: assert property (s_rd_last |=>
    !tx_valid_r && state_r == mcc_pkg::MCC_IDLE)
    else $error("read answer not six bytes");
  AST_NO_ACK_BAD: assert property (s_bad_cmd |=>
    state_r == mcc_pkg::MCC_IDLE && !tx_valid_r)
    else $error("unknown command acknowledged");
  AST_WR_ACK_END: assert property (s_wr_ack_taken |=>
    state_r == mcc_pkg::MCC_IDLE && !tx_valid_r)
    else $error("write answer longer than acknowledge");
  AST_PWR_PAD: assert property (s_pwr_pad |=>
    tx_byte_r == `MCC_PAD)
    else $error("power read not padded");
  AST_PHASE_ORDER: assert property (s_word1_next |=>
    tx_byte_r == words[dec_r.base + 4'h1][15:8])
    else $error("phase B word out of order");

endmodule : mcc_cmd
`default_nettype wire

// ---- core/mcc_params.svh ----
// Constants of the calibration command handler
`ifndef MCC_PARAMS_SVH
`define MCC_PARAMS_SVH

// Packet framing
`define MCC_SOP        8'hee
`define MCC_PAD        8'h00
`define MCC_ACK_OFS    8'h30
`define MCC_PKT_LEN    4'ha
`define MCC_CMD_POS    4'h2
`define MCC_DAT_FIRST  4'h3
`define MCC_DAT_LAST   4'h8
`define MCC_RSP_LAST   3'h5

// Read commands
`define MCC_RD_CUR_LO  8'h02
`define MCC_RD_CUR_HI  8'h03
`define MCC_RD_PLO_A   8'h07
`define MCC_RD_PLO_B   8'h09
`define MCC_RD_PLO_C   8'h0b
`define MCC_RD_PHI_A   8'h06
`define MCC_RD_PHI_B   8'h08
`define MCC_RD_PHI_C   8'h0a
`define MCC_RD_COMP    8'h15

// Write commands (phase C low-gain power code kept as printed)
`define MCC_WR_CUR_LO  8'h82
`define MCC_WR_CUR_HI  8'h83
`define MCC_WR_PLO_A   8'h87
`define MCC_WR_PLO_B   8'h89
`define MCC_WR_PLO_C   8'hb9
`define MCC_WR_PHI_A   8'h86
`define MCC_WR_PHI_B   8'h88
`define MCC_WR_PHI_C   8'h8a
`define MCC_WR_COMP    8'h95

// Word indices in the constant store
`define MCC_IX_CUR_LO  4'h0
`define MCC_IX_CUR_HI  4'h3
`define MCC_IX_PLO     4'h6
`define MCC_IX_PHI     4'h9
`define MCC_IX_COMP    4'hc
`define MCC_NWORDS     15

// Factory defaults
`define MCC_DEF_CUR_LO 16'h7000
`define MCC_DEF_CUR_HI 16'h2300
`define MCC_DEF_PLO    16'h3ee4
`define MCC_DEF_PHI    16'h0aa0
`define MCC_DEF_START  8'h08
`define MCC_DEF_GUARD  8'h20

`endif

// ---- core/mcc_pkg.sv ----
// Types shared by the calibration command handler
`default_nettype none
package mcc_pkg;

  typedef enum logic [2:0] {
    MCC_IDLE = 3'b000,
    MCC_CMD  = 3'b001,
    MCC_DATA = 3'b010,
    MCC_ACK  = 3'b011,
    MCC_SEND = 3'b100
  } mcc_state_t;

  // Decoded command
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [3:0] base;
    logic [1:0] nw;
  } mcc_dec_t;

  // Constants in use by the metering datapath
  typedef struct packed {
    logic [2:0][15:0] cur;
    logic [2:0][15:0] pwr;
    logic [2:0][7:0]  comp;
  } mcc_act_t;

endpackage : mcc_pkg
`default_nettype wire

// ---- core/mcc_store.sv ----
// Calibration constant store with factory defaults
`include "mcc_params.svh"
`default_nettype none
module mcc_store #(
  parameter int NW = `MCC_NWORDS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [2:0]           we,
  input  wire logic [3:0]           base,
  input  wire logic [2:0][15:0]     wdata,
  output logic      [NW-1:0][15:0]  words
);

  logic [15:0] mem_r [NW];

  // Factory default of one word
  function automatic logic [15:0] dflt(input int i);
    logic [15:0] v;
    v = `MCC_DEF_PHI;
    if (i < int'(`MCC_IX_CUR_HI)) begin
      v = `MCC_DEF_CUR_LO;
    end else if (i < int'(`MCC_IX_PLO)) begin
      v = `MCC_DEF_CUR_HI;
    end else if (i < int'(`MCC_IX_PHI)) begin
      v = `MCC_DEF_PLO;
    end else if (i >= int'(`MCC_IX_COMP)) begin
      v = {`MCC_DEF_GUARD, `MCC_DEF_START};
    end
    return v;
  endfunction : dflt

  // Reset stands in for a factory reload; writes persist otherwise
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NW; i++) begin
      if (rst) begin
        mem_r[i] <= dflt(i);
      end else begin
        for (int k = 0; k < 3; k++) begin
          if (we[k] && (int'(base) + k == i)) begin
            mem_r[i] <= wdata[k];
          end
        end
      end
    end
  end

  // Flat view for the reader
  always_comb begin
    for (int i = 0; i < NW; i++) begin
      words[i] = mem_r[i];
    end
  end

endmodule : mcc_store
`default_nettype wire

// ---- tb/mcc_host_model.sv ----
// Host-side model: sends command bytes and takes answer bytes
`default_nettype none
module mcc_host_model (
  input  wire logic       sys_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
  end

  // One pulse per byte; line then shows the inverse, never stale data
  task automatic put(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_byte  = b;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte  = ~b;
  endtask : put

  // Bounded wait for a byte, optional stall, then one take
  task automatic get(input int stall, output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b  = 8'h00;
    n  = 0;
    while (tx_valid !== 1'b1 && n < 64) begin
      @(negedge sys_clk);
      n++;
    end
    if (tx_valid === 1'b1) begin
      repeat (stall) @(negedge sys_clk);
      b        = tx_byte;
      tx_ready = 1'b1;
      @(negedge sys_clk); // Held across the sampling edge
      tx_ready = 1'b0;
      ok       = 1'b1;
      @(negedge sys_clk); // Ready low over one edge between takes
    end
  endtask : get
endmodule : mcc_host_model
`default_nettype wire

// ---- tb/mcc_cmd_tb.sv ----
// Self-checking bench of the calibration command interpreter
`include "mcc_params.svh"
`default_nettype none
module mcc_cmd_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic              sys_clk;
  logic              rst;
  logic              rx_valid;
  logic [7:0]        rx_byte;
  logic              tx_ready;
  logic              tx_valid;
  logic [7:0]        tx_byte;
  logic              gain_low;
  logic              busy;
  mcc_pkg::mcc_act_t act;
  int                failures;
  int                n_checks;
  logic [15:0]       m [15];
  logic [15:0]       seed;
  logic [7:0]        rdc [9] = '{8'h02, 8'h03, 8'h07, 8'h09, 8'h0b,
                                 8'h06, 8'h08, 8'h0a, 8'h15};
  logic [7:0]        wrc [9] = '{8'h82, 8'h83, 8'h87, 8'h89, 8'hb9,
                                 8'h86, 8'h88, 8'h8a, 8'h95};

  mcc_cmd mcc_cmd_i (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte),
    .gain_low (gain_low),
    .act      (act),
    .busy     (busy)
  );

  mcc_host_model mcc_host_model_i (
    .sys_clk  (sys_clk),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte)
  );

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Galois shift register; fixed seed keeps runs repeatable
  function automatic logic [15:0] step(input logic [15:0] x);
    return x[0] ? ((x >> 1) ^ 16'hb400) : (x >> 1);
  endfunction : step

  // Word slot: three per current gain, one per power phase, three comp
  function automatic int base(input int t);
    if (t < 2) return 3 * t;
    if (t == 8) return 12;
    return 4 + t;
  endfunction : base

  // Expected answer byte k of read kind t, high byte first
  function automatic logic [7:0] expb(input int t, input int k);
    logic [15:0] w;
    w = m[base(t) + ((t < 2 || t == 8) ? k / 2 : 0)];
    if (t >= 2 && t < 8 && k >= 2) return 8'h00;
    return (k % 2) ? w[7:0] : w[15:8];
  endfunction : expb

  task automatic chk(input logic [16:0] got, input logic [16:0] exp,
                     input string s);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("failures=%0d n_checks=%0d", failures, n_checks);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Reset with the bench store back at factory values
  task automatic do_reset;
    rst = 1'b1;
    for (int i = 0; i < 3; i++) begin
      m[i]      = `MCC_DEF_CUR_LO;
      m[3 + i]  = `MCC_DEF_CUR_HI;
      m[6 + i]  = `MCC_DEF_PLO;
      m[9 + i]  = `MCC_DEF_PHI;
      m[12 + i] = {`MCC_DEF_GUARD, `MCC_DEF_START};
    end
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
  endtask : do_reset

  // One packet; junk adds bytes sent while the answer is pending
  task automatic xfer(input int t, input bit wr, input bit junk);
    logic [7:0] d [6];
    logic [7:0] b;
    bit         ok;
    logic [7:0] code;
    logic [7:0] e;
    code = wr ? wrc[t] : rdc[t];
    for (int i = 0; i < 6; i++) begin
      seed = step(seed);
      d[i] = (t < 2 || t == 8 || i < 2) ? seed[7:0] : 8'h00;
    end
    mcc_host_model_i.put(8'hee);
    mcc_host_model_i.put(code);
    if (wr) begin
      for (int i = 0; i < 6; i++) mcc_host_model_i.put(d[i]);
      mcc_host_model_i.put(8'h00);
      chk(tx_valid, 1'b0, "early ack");
      mcc_host_model_i.put(seed[15:8]);
      for (int i = 0; i < 3; i++) begin
        if (t < 2 || t == 8) m[base(t) + i] = {d[2 * i], d[2 * i + 1]};
      end
      if (t >= 2 && t < 8) m[base(t)] = {d[0], d[1]};
    end
    if (junk) begin
      mcc_host_model_i.put(8'hee);
      mcc_host_model_i.put(rdc[1]);
      chk(busy, 1'b1, "busy");
    end
    seed = step(seed);
    mcc_host_model_i.get(seed[1:0], b, ok);
    chk({ok, b}, {1'b1, code + 8'h30}, "ack");
    for (int k = 0; k < 6 && !wr; k++) begin
      seed = step(seed);
      mcc_host_model_i.get(seed[1:0], b, ok);
      e = expb(t, k);
      chk({ok, b}, {1'b1, e}, "rd");
    end
  endtask : xfer

  // Constants in use follow the gain range
  task automatic chk_act;
    repeat (3) @(negedge sys_clk);
    for (int p = 0; p < 3; p++) begin
      chk(act.cur[p], gain_low ? m[p] : m[3 + p], "cur");
      chk(act.pwr[p], gain_low ? m[6 + p] : m[9 + p], "pwr");
      chk(act.comp[p], gain_low ? m[12 + p][7:0] : m[12 + p][15:8],
          "comp");
    end
  endtask : chk_act

  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    seed     = 16'h8784;
    gain_low = seed[1];
    do_reset();
    for (int t = 0; t < 9; t++) begin
      xfer(t, 1'b0, 1'b0);
    end
    for (int g = 0; g < 2; g++) begin
      gain_low = g[0];
      chk_act();
    end
    for (int r = 0; r < 3; r++) begin
      for (int t = 0; t < 9; t++) begin
        xfer(t, 1'b1, 1'b0);
        xfer(t, 1'b0, r == 1);
      end
      seed     = step(seed);
      gain_low = seed[0];
      chk_act();
    end
    // Stray idle byte, then an unknown command: no answer at all
    mcc_host_model_i.put(8'h55);
    mcc_host_model_i.put(8'hee);
    mcc_host_model_i.put(8'h44);
    repeat (4) @(negedge sys_clk);
    chk(tx_valid, 1'b0, "unknown cmd");
    chk(busy, 1'b0, "idle busy");
    do_reset();
    for (int t = 0; t < 9; t++) begin
      xfer(t, 1'b0, 1'b0);
    end
    results();
  end

  // Watchdog sized well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule : mcc_cmd_tb
`default_nettype wire
